// File: verilog/ppi_pkg.sv
package ppi_pkg;

    // ----------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------
    localparam logic [7:0] A_DATA  = 8'h00;  // Port data byte
    localparam logic [7:0] A_STAT  = 8'h04;  // Pin status, read only
    localparam logic [7:0] A_CTRL  = 8'h08;  // Pin control
    localparam logic [7:0] A_EADDR = 8'h0c;  // EPP address cycle
    localparam logic [7:0] A_EDATA = 8'h10;  // EPP data cycle
    localparam logic [7:0] A_ISTAT = 8'h14;  // Sticky events, W1C
    localparam logic [7:0] A_IMASK = 8'h18;  // Event enables

    // ----------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------
    localparam int CB_STRB = 0;  // 1: drive data strobe low
    localparam int CB_AFD  = 1;  // 1: drive autofeed low
    localparam int CB_INIT = 2;  // 0: drive init low, 1: release
    localparam int CB_SEL  = 3;  // 1: drive select low
    localparam int CB_DIR  = 5;  // 1: data lines are input
    localparam int CB_EPP  = 7;  // 1: EPP mode
    localparam int SB_EBSY = 0;  // EPP cycle in progress
    localparam int SB_ERR  = 3;  // Error pin level
    localparam int SB_SELD = 4;  // Selected pin level
    localparam int SB_PAPR = 5;  // Paper-out pin level
    localparam int SB_ACK  = 6;  // Acknowledge pin level
    localparam int SB_BUSY = 7;  // Busy/wait pin level
    localparam int IB_ACK  = 0;  // Acknowledge pulse seen
    localparam int IB_ERR  = 1;  // Error asserted
    localparam int IB_TO   = 2;  // EPP cycle aborted
    localparam int IB_PAPR = 3;  // Paper ran out

    // ----------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [3:0] IMASK_RST = 4'h0;

    // ----------------------------------------------------------
    // Timing
    // ----------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;    // ref_clk period
    localparam int EPP_TO_NS     = 10000;  // Longest wait extension
    localparam int EPP_TO_CYC    = (EPP_TO_NS / CLK_PERIOD_NS > 0) ? EPP_TO_NS / CLK_PERIOD_NS : 1;
    localparam logic [7:0] TO_LAST = 8'(EPP_TO_CYC - 1);

    // EPP cycle sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_STRB  = 2'b10,
        ST_DONE  = 2'b11
    } ppi_state_e;

endpackage

// File: verilog/ppi_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
module ppi_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;  // First stage, read only by dout

    // Capture then retime
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule // ppi_sync2

// File: verilog/ppi_port.sv
// Summary of operation
// - Strobe low marks valid data byte
// - Control bit zero releases strobe, select
// - Init low resets; bit one releases
// - Select low selects printer per bit
// - EPP address strobe; abort returns high
// - EPP write strobe low; abort forces high
// - Data lines driven out, sampled in
// - EPP data strobe; abort returns high
module ppi_port
    import ppi_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic [7:0]  port_data_lines_in,
    output logic      [7:0]  port_data_lines_out,
    output logic             port_data_lines_oe_n,
    output logic             data_strobe_or_write_strobe_out,
    output logic             data_strobe_or_write_strobe_oe_n,
    output logic             autofeed_or_data_strobe_out,
    output logic             autofeed_or_data_strobe_oe_n,
    output logic             select_in_or_addr_strobe_out,
    output logic             select_in_or_addr_strobe_oe_n,
    output logic             init_out,
    output logic             init_oe_n,
    input  wire logic        error_n_in,
    input  wire logic        paper_out_in,
    input  wire logic        printer_selected_in,
    input  wire logic        ack_n_in,
    input  wire logic        busy_or_wait_n_in
);

    // ----------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------
    logic [12:0] pins_s;       // Retimed pin levels
    logic [7:0]  pd_s;         // Data lines
    logic        err_s;        // Error, low active
    logic        paper_s;      // Paper out
    logic        sel_s;        // Printer selected
    logic        ack_s;        // Acknowledge, low active
    logic        busy_s;       // Busy, or wait (low = extend)

    ppi_sync2 #(.WIDTH(13)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     ({busy_or_wait_n_in, ack_n_in, printer_selected_in,
                   paper_out_in, error_n_in, port_data_lines_in}),
        .dout    (pins_s)
    );

    assign pd_s    = pins_s[7:0];
    assign err_s   = pins_s[8];
    assign paper_s = pins_s[9];
    assign sel_s   = pins_s[10];
    assign ack_s   = pins_s[11];
    assign busy_s  = pins_s[12];

    // ----------------------------------------------------------
    // Register state
    // ----------------------------------------------------------
    logic [7:0]  ctrl_reg;     // Pin control
    logic [7:0]  data_reg;     // Outgoing byte
    logic [3:0]  istat_reg;    // Sticky events
    logic [3:0]  imask_reg;    // Event enables
    logic [3:0]  events;       // Event pulses this cycle
    logic        err_d_reg;    // Previous error level
    logic        ack_d_reg;    // Previous ack level
    logic        paper_d_reg;  // Previous paper level
    logic        strobe_reg;   // Compatibility strobe granted
    logic        epp_on;       // EPP mode selected
    logic        setup_ph;     // APB setup cycle
    logic        access_ph;    // APB access, not yet answered
    logic        xfer;         // APB transfer completes
    logic        epp_hit;      // Address is an EPP cycle port
    logic        mapped;       // Address is a plain register
    logic [7:0]  stat_val;     // Live status byte
    logic [31:0] rd_val;       // Plain read data

    assign epp_on    = ctrl_reg[CB_EPP];
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & ~pready;
    assign xfer      = psel & penable & pready;
    assign epp_hit   = (paddr == A_EADDR) | (paddr == A_EDATA);
    assign mapped    = (paddr == A_DATA) | (paddr == A_STAT) | (paddr == A_CTRL)
                     | (paddr == A_ISTAT) | (paddr == A_IMASK);

    // ----------------------------------------------------------
    // EPP cycle sequencer
    // ----------------------------------------------------------
    ppi_state_e  state_reg;    // Current state
    ppi_state_e  state_next;   // Next state
    logic [7:0]  to_cnt_reg;   // Wait extension counter
    logic        is_wr_reg;    // Cycle is a write
    logic        is_addr_reg;  // Cycle is an address cycle
    logic        cyc_wr;       // Write flag valid from start
    logic        cyc_addr;     // Address flag valid from start
    logic        epp_start;    // Launch a cycle
    logic        abort;        // Extension ran too long
    logic [7:0]  epp_wdat_reg; // Byte to send
    logic [7:0]  epp_rd_reg;   // Byte received

    assign epp_start = access_ph & epp_hit & epp_on & (state_reg == ST_IDLE);
    assign cyc_wr    = (state_reg == ST_IDLE) ? pwrite : is_wr_reg;
    assign cyc_addr  = (state_reg == ST_IDLE) ? (paddr == A_EADDR) : is_addr_reg;

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        abort      = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (epp_start) begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                state_next = ST_STRB;
            end
            ST_STRB: begin
                if (busy_s) begin
                    state_next = ST_DONE;
                end else if (to_cnt_reg == TO_LAST) begin
                    abort      = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State and cycle attributes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            is_wr_reg    <= 1'b0;
            is_addr_reg  <= 1'b0;
            epp_wdat_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (epp_start) begin
                is_wr_reg    <= pwrite;
                is_addr_reg  <= (paddr == A_EADDR);
                epp_wdat_reg <= pwdata[7:0];
            end
        end
    end

    // Extension timer and read capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            to_cnt_reg <= 8'h00;
            epp_rd_reg <= 8'h00;
        end else begin
            if (state_reg == ST_STRB) begin
                to_cnt_reg <= to_cnt_reg + 8'h01;
            end else begin
                to_cnt_reg <= 8'h00;
            end
            if ((state_reg == ST_STRB) && busy_s && !is_wr_reg) begin
                epp_rd_reg <= pd_s;
            end
        end
    end

    // ----------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------
    // Status byte from pin levels and the sequencer busy flag
    always_comb begin
        stat_val          = 8'h00;
        stat_val[SB_EBSY] = (state_reg != ST_IDLE);
        stat_val[SB_ERR]  = err_s;
        stat_val[SB_SELD] = sel_s;
        stat_val[SB_PAPR] = paper_s;
        stat_val[SB_ACK]  = ack_s;
        stat_val[SB_BUSY] = busy_s;
    end

    // Plain register read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            A_DATA:  rd_val[7:0] = (ctrl_reg[CB_DIR] || epp_on) ? pd_s : data_reg;
            A_STAT:  rd_val[7:0] = stat_val;
            A_CTRL:  rd_val[7:0] = ctrl_reg;
            A_ISTAT: rd_val[3:0] = istat_reg;
            A_IMASK: rd_val[3:0] = imask_reg;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Answer: plain registers with no wait state, EPP ports after cycle when EPP mode is on
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (setup_ph && !(epp_hit && epp_on)) begin
                pready  <= 1'b1;
                prdata  <= rd_val;
                pslverr <= ~mapped;
            end else if ((state_reg == ST_DONE) || abort) begin
                pready  <= 1'b1;
                prdata  <= {24'h000000, epp_rd_reg};
                pslverr <= abort;
            end
        end
    end

    // Writable registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg  <= CTRL_RST;
            data_reg  <= DATA_RST;
            imask_reg <= IMASK_RST;
        end else if (xfer && pwrite && !pslverr) begin
            case (paddr)
                A_DATA:  data_reg  <= pwdata[7:0];
                A_CTRL:  ctrl_reg  <= pwdata[7:0];
                A_IMASK: imask_reg <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------
    // Edge history
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_d_reg   <= 1'b0;
            ack_d_reg   <= 1'b0;
            paper_d_reg <= 1'b0;
        end else begin
            err_d_reg   <= err_s;
            ack_d_reg   <= ack_s;
            paper_d_reg <= paper_s;
        end
    end

    assign events[IB_ACK]  = ack_d_reg & ~ack_s;
    assign events[IB_ERR]  = err_d_reg & ~err_s;
    assign events[IB_TO]   = abort;
    assign events[IB_PAPR] = ~paper_d_reg & paper_s;

    // Sticky bits, set beats write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            istat_reg <= 4'h0;
        end else if (xfer && pwrite && (paddr == A_ISTAT)) begin
            istat_reg <= (istat_reg & ~pwdata[3:0]) | events;
        end else begin
            istat_reg <= istat_reg | events;
        end
    end

    // Level interrupt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_reg & imask_reg);
        end
    end

    // ----------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------
    // strobe held off while busy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strobe_reg <= 1'b0;
        end else if (!ctrl_reg[CB_STRB] || epp_on) begin
            strobe_reg <= 1'b0;
        end else if (!busy_s) begin
            strobe_reg <= 1'b1;
        end
    end

    // Registered pin levels and enables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_strobe_or_write_strobe_out  <= 1'b0;
            data_strobe_or_write_strobe_oe_n <= 1'b1;
            autofeed_or_data_strobe_out      <= 1'b0;
            autofeed_or_data_strobe_oe_n     <= 1'b1;
            select_in_or_addr_strobe_out     <= 1'b0;
            select_in_or_addr_strobe_oe_n    <= 1'b1;
            init_out                         <= 1'b0;
            init_oe_n                        <= 1'b0;
            port_data_lines_out              <= 8'h00;
            port_data_lines_oe_n             <= 1'b1;
        end else begin
            init_out  <= 1'b0;
            init_oe_n <= ctrl_reg[CB_INIT];
            if (epp_on) begin
                select_in_or_addr_strobe_out  <= ~((state_next == ST_STRB) & cyc_addr);
                select_in_or_addr_strobe_oe_n <= 1'b0;
                autofeed_or_data_strobe_out   <= ~((state_next == ST_STRB) & ~cyc_addr);
                autofeed_or_data_strobe_oe_n  <= 1'b0;
                data_strobe_or_write_strobe_out  <= ~(((state_next == ST_SETUP) |
                                                      (state_next == ST_STRB)) & cyc_wr);
                data_strobe_or_write_strobe_oe_n <= 1'b0;
                port_data_lines_out  <= (state_reg == ST_IDLE) ? pwdata[7:0] : epp_wdat_reg;
                port_data_lines_oe_n <= ~((state_next != ST_IDLE) & cyc_wr);
            end else begin
                data_strobe_or_write_strobe_out  <= 1'b0;
                data_strobe_or_write_strobe_oe_n <= ~strobe_reg;
                autofeed_or_data_strobe_out      <= 1'b0;
                autofeed_or_data_strobe_oe_n     <= ~ctrl_reg[CB_AFD];
                select_in_or_addr_strobe_out     <= 1'b0;
                select_in_or_addr_strobe_oe_n    <= ~ctrl_reg[CB_SEL];
                port_data_lines_out  <= data_reg;
                port_data_lines_oe_n <= ctrl_reg[CB_DIR];
            end
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    a_strobe_busy_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!epp_on && $fell(data_strobe_or_write_strobe_oe_n)) |-> !$past(busy_s, 2))
        else $error("Strobe started while busy");

    a_strobe_release: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!ctrl_reg[CB_EPP] && !ctrl_reg[CB_STRB]) |=> ##1 data_strobe_or_write_strobe_oe_n)
        else $error("Strobe not released");

    a_init_drive: assert property (
        @(posedge ref_clk) disable iff (rst)
        ctrl_reg[CB_INIT] |=> (init_oe_n == $past(ctrl_reg[CB_INIT])) && !init_out)
        else $error("Init not following control bit");

    a_select_drive: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!epp_on && ctrl_reg[CB_SEL]) |=> !select_in_or_addr_strobe_oe_n && !select_in_or_addr_strobe_out)
        else $error("Select not driven low");

    a_addr_abort: assert property (
        @(posedge ref_clk) disable iff (rst)
        (abort && epp_on) |=> select_in_or_addr_strobe_out && (state_reg == ST_IDLE))
        else $error("Address strobe not high after abort");

    a_write_abort: assert property (
        @(posedge ref_clk) disable iff (rst)
        (abort && epp_on) |=> data_strobe_or_write_strobe_out && pslverr && pready)
        else $error("Write strobe not high after abort");

    a_write_low: assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_reg == ST_STRB && is_wr_reg && epp_on) |-> !data_strobe_or_write_strobe_out)
        else $error("Write strobe not low in write cycle");

    a_data_abort: assert property (
        @(posedge ref_clk) disable iff (rst)
        (abort && epp_on) |=> autofeed_or_data_strobe_out)
        else $error("Data strobe not high after abort");

    a_data_drive: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!epp_on && !ctrl_reg[CB_DIR]) |=> !port_data_lines_oe_n && (port_data_lines_out == $past(data_reg)))
        else $error("Data lines not driven");

    a_wait_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        (state_reg == ST_STRB && !busy_s && !abort) |=> (state_reg == ST_STRB))
        else $error("Cycle ended during wait");

    a_error_event: assert property (
        @(posedge ref_clk) disable iff (rst)
        $fell(err_s) |=> istat_reg[IB_ERR])
        else $error("Error event not latched");

endmodule // ppi_port

// File: tb/ppi_prn_model.sv
// Printer / EPP peripheral stand-in
module ppi_prn_model (
    input  wire logic       ref_clk,
    input  wire logic       epp,
    input  wire logic       hold_busy,
    input  wire logic [7:0] wait_cyc,
    input  wire logic [7:0] rd_byte,
    input  wire logic       strobe_pin,
    input  wire logic       ds_pin,
    input  wire logic       as_pin,
    input  wire logic [7:0] data_pin,
    input  wire logic       wr_pin,
    output logic            ack_n,
    output logic            bw_pin,
    output logic            drv_oe,
    output logic      [7:0] drv,
    output logic      [7:0] last_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       busy  = 1'b0;   // Printing a byte
    logic       strobe_q = 1'b1;  // Strobe one cycle back
    logic [7:0] cnt   = 8'h00;  // Print time
    logic [7:0] ecnt  = 8'h00;  // EPP strobe time
    always @(posedge ref_clk) begin
        strobe_q <= strobe_pin;
        if (!epp && strobe_q && !strobe_pin) begin
            last_byte <= data_pin;
            busy      <= 1'b1;
            cnt       <= 8'h00;
        end else if (busy) begin
            cnt  <= cnt + 8'h01;
            busy <= (cnt != 8'h05);
        end
    end
    always @(posedge ref_clk) ack_n <= !(busy && cnt >= 8'h02 && cnt < 8'h04);
    always @(posedge ref_clk) ecnt <= (!ds_pin || !as_pin) ? ecnt + 8'h01 : 8'h00;
    assign bw_pin = epp ? (ecnt != 8'h00 && ecnt >= wait_cyc) : (busy || hold_busy);
    // Drive bus only on EPP reads
    assign drv_oe = epp && !ds_pin && wr_pin;
    assign drv    = rd_byte;
endmodule // ppi_prn_model

// File: tb/test_ppi_port.sv
module test_ppi_port
    import ppi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, dout, din, drv, lastb, dl = 8'h00, wait_cyc = 8'h03;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, irq, e, d_oe, sw_o, sw_oe, af_o, af_oe, sa_o, sa_oe;
    logic        in_o, in_oe, drv_oe, ack_n, bw;
    logic        err_n = 1'b1, paper = 1'b0, seld = 1'b0, epp = 1'b0, hold = 1'b0;
    logic [2:0]  saw = 3'b000;  // Address, data, write strobe lows seen
    logic        saw_clr = 1'b0;  // Restart the strobe record
    int          bad_count = 0, samples_checked = 0, cyc = 0;
    wire logic   sw_p = sw_oe | sw_o;  // Pull-ups on released pins
    wire logic   af_p = af_oe | af_o;
    wire logic   sa_p = sa_oe | sa_o;
    // Control byte, then oe_n of strobe, autofeed, select, init, data
    localparam logic [12:0] ROWS [6] = '{{8'h00, 5'b11100}, {8'h01, 5'b01100}, {8'h04, 5'b11110},
                                         {8'h08, 5'b11000}, {8'h22, 5'b10101}, {8'h0f, 5'b00010}};
    assign din = !d_oe ? dout : (drv_oe ? drv : ~dl);
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) dl <= din;
    always @(posedge ref_clk) saw <= saw_clr ? 3'b000 : (saw | ~{sa_p, af_p, sw_p});
    ppi_port ppi_port_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .port_data_lines_in(din), .port_data_lines_out(dout), .port_data_lines_oe_n(d_oe),
        .data_strobe_or_write_strobe_out(sw_o), .data_strobe_or_write_strobe_oe_n(sw_oe),
        .autofeed_or_data_strobe_out(af_o), .autofeed_or_data_strobe_oe_n(af_oe),
        .select_in_or_addr_strobe_out(sa_o), .select_in_or_addr_strobe_oe_n(sa_oe),
        .init_out(in_o), .init_oe_n(in_oe), .error_n_in(err_n), .paper_out_in(paper),
        .printer_selected_in(seld), .ack_n_in(ack_n), .busy_or_wait_n_in(bw));
    ppi_prn_model ppi_prn_model_i (.ref_clk, .epp, .hold_busy(hold), .wait_cyc, .rd_byte(8'h5a),
        .strobe_pin(sw_p), .ds_pin(af_p), .as_pin(sa_p), .data_pin(din), .wr_pin(sw_p), .ack_n,
        .bw_pin(bw), .drv_oe, .drv, .last_byte(lastb));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer, answer in r and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic epp_op(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        saw_clr <= 1'b1;
        @(posedge ref_clk);
        saw_clr <= 1'b0;
        apb(w, a, d);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        check("rst_pins", {sw_oe, af_oe, sa_oe, in_oe, d_oe, pready}, 6'b111010);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b1, A_DATA, 32'ha5);
        foreach (ROWS[i]) begin
            apb(1'b1, A_CTRL, {24'h0, ROWS[i][12:5]});
            repeat (4) @(posedge ref_clk);
            check("oe_n", {sw_oe, af_oe, sa_oe, in_oe, d_oe}, ROWS[i][4:0]);
        end
        check("dout", dout, 8'ha5);
        check("printed", lastb, 8'ha5);
        check("init_lvl", in_o, 1'b0);
        hold <= 1'b1;
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_CTRL, 32'h1);
        repeat (5) @(posedge ref_clk);
        check("stb_busy", sw_oe, 1'b1);
        hold <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("stb_free", sw_p, 1'b0);
        apb(1'b0, A_ISTAT, 32'h0);
        check("ack_ev", r[IB_ACK], 1'b1);
        epp <= 1'b1;
        apb(1'b1, A_CTRL, 32'h80);
        epp_op(1'b1, A_EADDR, 32'h3c);
        check("ea_wr", {e, saw}, 4'b0101);
        epp_op(1'b1, A_EDATA, 32'hc3);
        check("ed_wr", {e, saw}, 4'b0011);
        epp_op(1'b0, A_EDATA, 32'h0);
        check("ed_rd", {e, saw, r[7:0]}, {4'b0010, 8'h5a});
        wait_cyc <= 8'hc8;
        epp_op(1'b1, A_EDATA, 32'h1);
        @(negedge ref_clk);
        check("abort", {e, sa_p, af_p, sw_p}, 4'b1111);
        apb(1'b0, A_ISTAT, 32'h0);
        check("to_ev", r[IB_TO], 1'b1);
        epp <= 1'b0;
        wait_cyc <= 8'h03;
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_EADDR, 32'h0);
        check("epp_off", e, 1'b1);
        apb(1'b1, A_ISTAT, 32'hf);
        apb(1'b1, A_IMASK, 32'h2);
        err_n <= 1'b0;
        paper <= 1'b1;
        seld <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("irq_on", irq, 1'b1);
        apb(1'b0, A_STAT, 32'h0);
        check("stat", r[5:3], 3'b110);
        apb(1'b1, A_IMASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("irq_mask", irq, 1'b0);
        apb(1'b1, A_ISTAT, 32'h2);
        apb(1'b1, A_IMASK, 32'h2);
        repeat (2) @(posedge ref_clk);
        check("irq_clr", irq, 1'b0);
        apb(1'b0, A_ISTAT, 32'h0);
        check("istat", r[3:0], 4'h8);
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped", {e, r}, {1'b1, 32'h0});
        end_sim;
    end
endmodule // test_ppi_port
